/* File: hdl/aics_sequencer.sv */
// input configuration, coding resolution and channel sequence for a sar converter
// assumes the serial clock and chip select come from a host, asynchronous to i_clk,
// and that the serial clock runs well below a quarter of i_clk
`timescale 1ns/1ps

// What this block does
// - code 10001 loads pseudo-differential config
// - code 10010 loads bipolar config
// - bits 10:3 pick pseudo-differential per pair
// - bit 2 selects common reference mode
// - bits 10:3 pick bipolar per pair
// - two's complement only for plain bipolar
// - pseudo-differential beats bipolar, binary coding
// - common reference overrides pair bits, binary
// - either pair bit gives paired result
// - channel field or scan mask by mode
// - sequence up to 256 entries
// - pattern sent as 4-bit nibbles
// - new pattern active by next frame start
// - missing entries become channel 0
// - surplus nibbles ignored until frame end
// - broken nibble becomes channel 0
// - results follow sequence order from first
// - shutdown honoured after last readout
// - code 10110 sets length value plus one
// - msb one is config, zero is mode
module aics_sequencer #(
    parameter int SEQ_DEPTH = 256                     // entries the pattern memory holds
) (
    input  wire logic               i_clk,            // core clock, 10 MHz
    input  wire logic               i_rst,            // synchronous reset, active high
    input  wire logic               i_sclk,           // serial clock from host
    input  wire logic               i_cs_n,           // chip select from host, active low
    input  wire logic               i_din,            // serial data from host
    input  wire logic               i_conv_next,      // analog side wants next conversion
    input  wire logic [15:0]        i_custom_scan_mask, // channels of the custom scans
    output logic [15:0]             o_mode_word,      // last mode control word taken
    output logic                    o_mode_strobe,    // pulse when a mode word lands
    output aics_pkg::aics_conv_t    o_conv,           // decoded conversion request
    output logic                    o_seq_last,       // conversion is the last entry
    output logic                    o_shutdown        // shutdown granted after readout
);
    import aics_pkg::*;

    // elaboration check: the pattern memory is indexed with eight bits
    if (SEQ_DEPTH < 1 || SEQ_DEPTH > SEQ_MAX) begin : g_depth_check
        $error("SEQ_DEPTH out of range");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: three stages, change counts when stages two and three agree
    logic [2:0] sclk_sync_q;                          // serial clock stages
    logic [2:0] cs_sync_q;                            // chip select stages
    logic [2:0] din_sync_q;                           // data stages
    logic       sclk_st_q;                            // filtered serial clock
    logic       cs_n_st_q;                            // filtered chip select
    logic       din_st_q;                             // filtered data

    // shift pins in
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sclk_sync_q <= 3'h0;
            cs_sync_q   <= 3'h7;
            din_sync_q  <= 3'h0;
        end else begin
            sclk_sync_q <= {sclk_sync_q[1:0], i_sclk};
            cs_sync_q   <= {cs_sync_q[1:0], i_cs_n};
            din_sync_q  <= {din_sync_q[1:0], i_din};
        end
    end

    // accept a level only once stages two and three agree
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sclk_st_q <= 1'b0;
            cs_n_st_q <= 1'b1;
            din_st_q  <= 1'b0;
        end else begin
            if (sclk_sync_q[1] == sclk_sync_q[2]) begin
                sclk_st_q <= sclk_sync_q[2];
            end
            if (cs_sync_q[1] == cs_sync_q[2]) begin
                cs_n_st_q <= cs_sync_q[2];
            end
            if (din_sync_q[1] == din_sync_q[2]) begin
                din_st_q <= din_sync_q[2];
            end
        end
    end

    // edge events derived from the filtered levels
    logic sclk_d1_q;                                  // filtered clock, one cycle old
    logic cs_d1_q;                                    // filtered select, one cycle old
    logic din_d1_q;                                   // data aligned with edge detect
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sclk_d1_q <= 1'b0;
            cs_d1_q   <= 1'b1;
            din_d1_q  <= 1'b0;
        end else begin
            sclk_d1_q <= sclk_st_q;
            cs_d1_q   <= cs_n_st_q;
            din_d1_q  <= din_st_q;
        end
    end

    logic sclk_rise;                                  // host clock rising edge seen
    logic cs_fall;                                    // frame start
    logic cs_rise;                                    // frame end
    logic in_frame;                                   // chip select held low
    assign sclk_rise = sclk_st_q & ~sclk_d1_q;
    assign cs_fall   = ~cs_n_st_q & cs_d1_q;
    assign cs_rise   = cs_n_st_q & ~cs_d1_q;
    assign in_frame  = ~cs_d1_q;

    ////////////////////////////////////////////////////////////////////////////////
    // word assembly: data taken on rising serial clock within a frame
    logic [WORD_W-1:0] shift_q;                       // incoming bits, msb first
    logic [4:0]        bit_cnt_q;                     // bits of the current word
    logic              word_done;                     // sixteenth bit arrives now
    logic [WORD_W-1:0] word_now;                      // word including this bit
    logic              pattern_frame_q;               // frame carries nibbles
    assign word_now  = {shift_q[WORD_W-2:0], din_d1_q};
    assign word_done = in_frame & sclk_rise & ~pattern_frame_q
                       & (bit_cnt_q == 5'(WORD_W - 1));

    // shifter, cleared at every frame start
    always_ff @(posedge i_clk) begin
        if (i_rst || cs_fall) begin
            shift_q   <= '0;
            bit_cnt_q <= 5'h00;
        end else if (in_frame && sclk_rise && !pattern_frame_q) begin
            shift_q   <= word_now;
            bit_cnt_q <= word_done ? 5'h00 : bit_cnt_q + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // configuration registers
    logic [7:0] pdiff_q;                              // pair_pseudo_diff_bit per pair
    logic       com_q;                                // common_ref_mode
    logic [7:0] bip_q;                                // pair_bipolar_bit per pair
    logic [7:0] len_q;                                // sequence_length_field
    logic       arm_q;                                // next frame is pattern frame

    // config writes decoded by select code
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pdiff_q <= PAIR_RESET;
            com_q   <= COM_RESET;
            bip_q   <= PAIR_RESET;
            len_q   <= LEN_RESET;
        end else if (word_done && word_now[SEL_HI]) begin
            case (word_now[SEL_HI:SEL_LO])
                PSEUDO_DIFF_SELECT_CODE: begin
                    pdiff_q <= word_now[PAIR_HI:PAIR_LO];
                    com_q   <= word_now[COM_BIT];
                end
                BIPOLAR_SELECT_CODE: begin
                    bip_q <= word_now[PAIR_HI:PAIR_LO];
                end
                SEQUENCE_SELECT_CODE: begin
                    len_q <= word_now[PAIR_HI:PAIR_LO];
                end
                default: begin
                    // other config registers live elsewhere
                end
            endcase
        end
    end

    // length frame arms the pattern frame
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            arm_q           <= 1'b0;
            pattern_frame_q <= 1'b0;
        end else if (cs_fall) begin
            pattern_frame_q <= arm_q;
            arm_q           <= 1'b0;
        end else if (word_done && word_now[SEL_HI:SEL_LO] == SEQUENCE_SELECT_CODE) begin
            arm_q <= 1'b1;
        end else if (cs_rise) begin
            pattern_frame_q <= 1'b0;
        end
    end

    // mode word capture; the 4-bit mode field sits in bits 10:7
    logic [WORD_W-1:0] mode_word_q;                   // last mode control word
    logic              mode_strobe_q;                 // landed this cycle
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mode_word_q   <= '0;
            mode_strobe_q <= 1'b0;
        end else begin
            mode_strobe_q <= word_done & ~word_now[SEL_HI];
            if (word_done && !word_now[SEL_HI]) begin
                mode_word_q <= word_now;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pattern loading straight into the active memory; the entry count updates at the pattern frame end
    // up to 256 entries
    logic [3:0] pat_mem [SEQ_DEPTH];                  // active pattern
    logic [3:0] nib_q;                                // nibble being collected
    logic [1:0] nib_bits_q;                           // bits of that nibble
    logic [8:0] wr_idx_q;                             // nibbles stored this frame
    logic [8:0] stored_q;                             // entries the last pattern frame wrote
    logic       room;                                 // entry slot still open this frame
    logic [8:0] seq_len;                              // length as count
    assign seq_len = {1'b0, len_q} + 9'h001;
    // surplus beyond the length, or beyond the memory, is never written
    assign room    = (wr_idx_q < seq_len) && (wr_idx_q < 9'(SEQ_DEPTH));

    always_ff @(posedge i_clk) begin
        if (i_rst || cs_fall) begin
            nib_q      <= CHAN_RESET;
            nib_bits_q <= 2'h0;
            wr_idx_q   <= 9'h000;
        end else if (pattern_frame_q && in_frame && sclk_rise) begin
            nib_q      <= {nib_q[2:0], din_d1_q};
            nib_bits_q <= nib_bits_q + 2'h1;
            if (nib_bits_q == 2'h3 && room) begin
                wr_idx_q <= wr_idx_q + 9'h001;
            end
        end
    end

    // entries from the first unfinished one on read as channel 0
    // a count instead of a zero fill makes the pattern usable at frame end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            stored_q <= 9'h000;
        end else if (pattern_frame_q && cs_rise) begin
            stored_q <= wr_idx_q;
        end
    end

    // memory write port; only whole nibbles inside the length are written
    always_ff @(posedge i_clk) begin
        if (pattern_frame_q && in_frame && sclk_rise && nib_bits_q == 2'h3 && room) begin
            pat_mem[wr_idx_q[7:0]] <= {nib_q[2:0], din_d1_q};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sequence playback and channel source choice
    aics_mode_t mode_now;                             // scan mode from mode word
    logic [3:0] chsel;                                // channel_select_field
    assign mode_now = aics_mode_t'(mode_word_q[10:7]);
    assign chsel    = mode_word_q[6:3];

    logic [8:0]  rd_idx_q;                            // sequence entry to convert
    logic [3:0]  scan_ch_q;                           // custom scan walker
    logic        shut_req_q;                          // shutdown asked for
    logic [3:0]  pick;                                // channel chosen now
    logic        is_last;                             // entry is the final one

    // next set channel of the custom scan mask after the walker
    function automatic logic [3:0] next_scan(input logic [15:0] mask, input logic [3:0] cur);
        logic [3:0] c;
        logic       hit;
        c   = cur;
        hit = 1'b0;
        for (int k = 1; k <= 16; k++) begin
            if (!hit && mask[4'(cur + 4'(k))]) begin
                c   = 4'(cur + 4'(k));
                hit = 1'b1;
            end
        end
        return c;
    endfunction

    always_comb begin
        pick    = chsel;
        is_last = 1'b0;
        case (mode_now)
            AICS_CUST_INT, AICS_CUST_EXT: pick = next_scan(i_custom_scan_mask, scan_ch_q);
            AICS_SEQ_EXT: begin
                pick    = (rd_idx_q < stored_q) ? pat_mem[rd_idx_q[7:0]] : CHAN_RESET;
                is_last = (rd_idx_q + 9'h001) >= seq_len;
            end
            default: pick = chsel;
        endcase
    end

    // playback restarts at entry zero on each mode word, or at a frame start other than a pattern frame's when the index lies past the length
    always_ff @(posedge i_clk) begin
        if (i_rst || mode_strobe_q || (cs_fall && pattern_frame_q == 1'b0
            && arm_q == 1'b0 && rd_idx_q >= seq_len)) begin
            rd_idx_q  <= 9'h000;
            scan_ch_q <= 4'hF;
        end else if (i_conv_next) begin
            rd_idx_q  <= is_last ? 9'h000 : rd_idx_q + 9'h001;
            scan_ch_q <= pick;
        end
    end

    // pair decode
    aics_conv_t conv_q;
    logic       last_q;
    logic [2:0] pr;
    assign pr = 3'(7 - 32'(pick[3:1]));               // bit 10 is pair 0/1
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            conv_q <= '0;
            last_q <= 1'b0;
        end else begin
            conv_q.valid      <= i_conv_next;
            last_q            <= i_conv_next & is_last;
            // the decoded fields stand until the next request
            if (i_conv_next) begin
                conv_q.channel    <= pick;
                conv_q.common_ref <= com_q;
                // either pair bit pairs the channels
                conv_q.paired     <= ~com_q & (pdiff_q[pr] | bip_q[pr]);
                // two's complement only for plain bipolar
                conv_q.twos_comp  <= ~com_q & ~pdiff_q[pr] & bip_q[pr];
            end
        end
    end

    logic last_done_q;                                // latest conversion was the final entry

    // remembered so the grant can wait for the end of the readout frame
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            last_done_q <= 1'b0;
        end else if (i_conv_next) begin
            last_done_q <= is_last;
        end
    end

    // shutdown request honoured after last entry read
    always_ff @(posedge i_clk) begin
        if (i_rst || (mode_strobe_q && !mode_word_q[2])) begin
            shut_req_q <= 1'b0;
            o_shutdown <= 1'b0;
        end else begin
            if (mode_strobe_q && mode_word_q[2]) begin
                shut_req_q <= 1'b1;
            end
            // grant at the frame end once the final entry has gone out
            if (shut_req_q && last_done_q && cs_rise) begin
                o_shutdown <= 1'b1;
            end
        end
    end

    assign o_mode_word   = mode_word_q;
    assign o_mode_strobe = mode_strobe_q;
    assign o_conv        = conv_q;
    assign o_seq_last    = last_q;

endmodule

/* File: hdl/aics_pkg.sv */
// shared constants and types of the adc input configuration sequencer
// assumes a single 10 MHz core clock and a serial link sampled on that clock
package aics_pkg;

    // word layout on the serial input
    localparam int  WORD_W        = 16;               // bits per instruction word
    localparam int  SEL_HI        = 15;               // select code top bit
    localparam int  SEL_LO        = 11;               // select code bottom bit
    localparam int  PAIR_HI       = 10;               // pair field top bit
    localparam int  PAIR_LO       = 3;                // pair field bottom bit
    localparam int  COM_BIT       = 2;                // common reference mode bit
    localparam int  NIB_W         = 4;                // pattern nibble width
    localparam int  SEQ_MAX       = 256;              // deepest sequence

    // select codes in bits 15:11
    localparam logic [4:0] PSEUDO_DIFF_SELECT_CODE = 5'h11;
    localparam logic [4:0] BIPOLAR_SELECT_CODE     = 5'h12;
    localparam logic [4:0] SEQUENCE_SELECT_CODE    = 5'h16;

    // values after reset
    localparam logic [7:0] PAIR_RESET  = 8'h00;
    localparam logic       COM_RESET   = 1'b0;
    localparam logic [7:0] LEN_RESET   = 8'h00;
    localparam logic [3:0] CHAN_RESET  = 4'h0;       // filler channel is channel 0

    // scan modes carried by the mode control word
    typedef enum logic [3:0] {
        AICS_MANUAL, AICS_REPEAT, AICS_STD_INT, AICS_STD_EXT,
        AICS_UPPER_INT, AICS_UPPER_SCAN_EXTERNAL_CLOCK, AICS_CUST_INT, AICS_CUST_EXT,
        AICS_SEQ_EXT
    } aics_mode_t;

    // decoded conversion to hand to the analog side
    typedef struct packed {
        logic       valid;       // one-cycle strobe
        logic [3:0] channel;     // selected channel number
        logic       paired;      // pair conversion instead of single channel
        logic       common_ref;  // measured against the shared negative input
        logic       twos_comp;   // output coding is two's complement
    } aics_conv_t;

endpackage

/* File: sim/aics_sequencer_props.sv */
// concurrent checks on the sequencer ports
// assumes one core clock domain with synchronous active high reset
`timescale 1ns/1ps
module aics_sequencer_props
    import aics_pkg::*;
#(
    parameter int SEQ_DEPTH = 256                     // matches the design
) (
    input wire logic             i_clk,
    input wire logic             i_rst,
    input wire logic             i_conv_next,
    input wire logic [15:0]      o_mode_word,
    input wire logic             o_mode_strobe,
    input wire aics_conv_t       o_conv,
    input wire logic             o_seq_last,
    input wire logic             o_shutdown
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    ////////////////////////////////////////////////////////////////////////////////
    // reset must clear the conversion and mode strobes and the shutdown grant, also in mid-run
    a_reset_quiet: assert property (
        disable iff (1'b0) i_rst |=> !o_conv.valid && !o_mode_strobe && !o_shutdown)
        else $error("outputs active after reset");
    a_valid_cause: assert property (o_conv.valid |-> $past(i_conv_next))
        else $error("conversion without request");
    a_conv_hold: assert property (!i_conv_next |=> $stable(o_conv.channel))
        else $error("channel moved without request");
    a_twos_coding: assert property (
        o_conv.valid && o_conv.twos_comp |-> o_conv.paired && !o_conv.common_ref)
        else $error("two's complement outside plain bipolar pair");
    a_common_single: assert property (
        o_conv.valid && o_conv.common_ref |-> !o_conv.paired && !o_conv.twos_comp)
        else $error("common reference not single binary");
    a_last_valid: assert property (o_seq_last |-> o_conv.valid)
        else $error("last flag without conversion");
    a_mode_msb: assert property (o_mode_word[15] == 1'b0)
        else $error("mode word with msb set");
    a_word_strobe: assert property ($changed(o_mode_word) |-> ##[0:2] o_mode_strobe)
        else $error("mode word changed without strobe");
    a_strobe_pulse: assert property (o_mode_strobe |=> !o_mode_strobe)
        else $error("mode strobe longer than one cycle");
    a_shut_req: assert property ($rose(o_shutdown) |-> o_mode_word[2])
        else $error("shutdown without request");
endmodule

bind aics_sequencer aics_sequencer_props #(.SEQ_DEPTH(SEQ_DEPTH)) i_props (
    .i_clk(i_clk), .i_rst(i_rst), .i_conv_next(i_conv_next), .o_mode_word(o_mode_word),
    .o_mode_strobe(o_mode_strobe), .o_conv(o_conv), .o_seq_last(o_seq_last),
    .o_shutdown(o_shutdown));

/* File: sim/aics_host_model.sv */
// host side of the serial port: frames words and nibble streams msb first
// assumes the serial clock half period is four core clock cycles (800 ns period)
`timescale 1ns/1ps
module aics_host_model (
    input  wire logic i_clk,    // core clock, used for pacing and for idle data toggling
    output logic      o_sclk,   // serial clock, still outside frames
    output logic      o_cs_n,   // chip select, active low
    output logic      o_din     // serial data
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_din  = 1'b0;
    end

    // idle data toggles so a stale bit never looks like valid data
    always @(posedge i_clk) begin
        if (o_cs_n) begin
            o_din <= ~o_din;
        end
    end

    // whole words and nibbles msb first
    task automatic frame(input logic [63:0] d, input int n);
        @(posedge i_clk) o_cs_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            @(posedge i_clk) o_din <= d[63-i];
            repeat (3) @(posedge i_clk);
            o_sclk <= 1'b1;
            repeat (4) @(posedge i_clk);
            o_sclk <= 1'b0;
        end
        repeat (4) @(posedge i_clk);
        o_cs_n <= 1'b1;
        repeat (12) @(posedge i_clk);
    endtask
endmodule

/* File: sim/aics_sequencer_tb_top.sv */
// self-checking bench of the sequencer: config decode, scan source, sequences
// assumes the host model paces the serial link and bind attaches the checker
`timescale 1ns/1ps
module aics_sequencer_tb_top;
    import aics_pkg::*;
    logic        i_clk, i_rst, i_conv_next;     // bench driven controls
    logic [15:0] mask;                          // custom scan mask
    logic        sclk, cs_n, din;               // serial link from host model
    logic [15:0] mode_word;
    logic        mode_strobe, seq_last, shutdown;
    aics_conv_t  conv_q;
    int          errors, n_tests;

    aics_host_model i_host (.i_clk(i_clk), .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din));
    aics_sequencer i_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
        .i_conv_next(i_conv_next), .i_custom_scan_mask(mask), .o_mode_word(mode_word),
        .o_mode_strobe(mode_strobe), .o_conv(conv_q), .o_seq_last(seq_last),
        .o_shutdown(shutdown));

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic stop_test;
        $display("errors %0d checks %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic wr(input logic [15:0] w);
        i_host.frame({w, 48'h0}, 16);
    endtask

    // one request pulse; the result is read one cycle later
    task automatic conv(output aics_conv_t c, output logic last);
        @(posedge i_clk) i_conv_next <= 1'b1;
        @(posedge i_clk) i_conv_next <= 1'b0;
        #1 c = conv_q;
        last = seq_last;
    endtask

    task automatic test_reset;
        aics_conv_t c;
        logic       l;
        #1 chk("shutdown", 16'h0000, {15'h0, shutdown});
        wr(16'h0000);
        conv(c, l);
        chk("coding after reset", 16'h0000, {13'h0, c.paired, c.twos_comp, c.common_ref});
    endtask

    task automatic test_decode;
        logic [7:0] uni[7] = '{8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h02, 8'h00};
        logic [7:0] bip[7] = '{8'h00, 8'h80, 8'h00, 8'h80, 8'h80, 8'h01, 8'h00};
        logic       com[7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
        logic [3:0] ch[7]  = '{4'h0, 4'h1, 4'h0, 4'h1, 4'h0, 4'hE, 4'h0};
        logic [3:0] md[7]  = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h3, 4'h6};
        aics_conv_t c;
        logic       l, u, b;
        logic [3:0] ce;
        for (int i = 0; i < 7; i++) begin
            wr({PSEUDO_DIFF_SELECT_CODE, uni[i], com[i], 2'b00});
            wr({BIPOLAR_SELECT_CODE, bip[i], 3'b000});
            wr(16'h9FFF);
            wr({5'b00000, md[i], ch[i], 3'b000});
            chk("mode word", {5'b00000, md[i], ch[i], 3'b000}, mode_word);
            conv(c, l);
            ce = (md[i] == 4'h6) ? 4'hD : ch[i];
            u = uni[i][7 - ce[3:1]];
            b = bip[i][7 - ce[3:1]];
            chk("channel", {12'h0, ce}, {12'h0, c.channel});
            chk("paired", {15'h0, !com[i] && (u || b)}, {15'h0, c.paired});
            chk("twos", {15'h0, !com[i] && !u && b}, {15'h0, c.twos_comp});
            chk("common", {15'h0, com[i]}, {15'h0, c.common_ref});
        end
    endtask

    // length frame, pattern frame, then mode word; entries past four expect channel 0
    task automatic seq(input logic [7:0] lv, input logic [63:0] pat, input int nb,
                       input logic [15:0] exp4);
        aics_conv_t c;
        logic       l;
        wr({SEQUENCE_SELECT_CODE, lv, 3'b000});
        i_host.frame(pat, nb);
        wr({5'b00000, 4'h8, 4'h0, 3'b000});
        for (int i = 0; i <= lv; i++) begin
            conv(c, l);
            chk("seq channel", (i < 4) ? {12'h0, exp4[15-4*i -: 4]} : 16'h0000,
                {12'h0, c.channel});
            chk("seq last", (i == lv) ? 16'h0001 : 16'h0000, {15'h0, l});
        end
    endtask

    // shutdown asked for mid-sequence is granted only after the last entry's frame
    task automatic test_seq;
        aics_conv_t c;
        logic       l;
        seq(8'h03, {4'h9, 4'h5, 2'b11, 54'h0}, 10, 16'h9500);
        seq(8'hFF, {4'hF, 60'h0}, 4, 16'hF000);
        seq(8'h01, {16'h3C77, 48'h0}, 16, 16'h3C00);
        conv(c, l);
        chk("shutdown early", 16'h0000, {15'h0, shutdown});
        wr({5'b00000, 4'h8, 4'h0, 3'b100});
        chk("shutdown before last", 16'h0000, {15'h0, shutdown});
        conv(c, l);
        conv(c, l);
        chk("last entry", 16'h0001, {15'h0, l});
        wr(16'h9FFF);
        chk("shutdown", 16'h0001, {15'h0, shutdown});
    endtask

    initial begin
        i_rst       = 1'b1;
        i_conv_next = 1'b0;
        mask        = 16'h2000;
        errors      = 0;
        n_tests     = 0;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_clk);
        test_reset;
        test_decode;
        test_seq;
        // mid-run reset must drop the shutdown grant and all configuration
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_clk);
        test_reset;
        stop_test;
    end

    // watchdog well beyond the expected sub-millisecond of traffic
    initial begin
        #8_000_000;
        errors++;
        stop_test;
    end
endmodule
